// ### rtl/cse_app_end.sv
// application end: reports completion errors to the core under software control
//
// How it works
// - posted request refused raises posted UR bit
// - core sets status and messages for posted UR
// - non-posted UR: send UR completion, then bit
// - core sets status and messages for non-posted UR
// - core reports its own UR cases itself
// - log bit rides with logged CA, UC, PUR and NPUR errors only, not timeouts
// - four header words written before log bit
// - header words at 81C, 820, 824, 828
// - pending high while count is nonzero; a request issued alongside an unmatched completion is not counted
// - each error bit pulses exactly one cycle
// - completer abort: send CA completion, then bit
// - unmatched completion raises unexpected-completion bit
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "cse_defs.svh"
module cse_app_end #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // AXI4-Lite register port
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // sideband toward the core
   cse_if.app               side,
   // master block activity
   input  wire logic        reqIssue,
   input  wire logic        cplRx,
   input  wire logic        reqRetire,
   // completion transmit request
   output logic             cplSendReq,
   output logic [2:0]       cplSendSts,
   input  wire logic        cplSent,
   // interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // all state
   typedef struct packed {
      cse_pkg::cse_app_state_type st;
      logic [2:0]                 kind;      // error bit being reported
      logic                       log;       // header logging wanted
      logic [1:0]                 word;      // header word being sent
      logic [3:0][31:0]           hdr;       // software copy of the header
      logic [`CSE_EV_W-1:0]       stat;      // sticky events
      logic [`CSE_EV_W-1:0]       mask;      // interrupt enables
      logic [CNT_W-1:0]           count;     // outstanding non-posted requests
      logic                       ucPend;    // unexpected completion to report
      logic [6:0]                 cplErr;
      logic                       lmiWr;
      logic [11:0]                lmiAddr;
      logic [31:0]                lmiDin;
      logic                       sendReq;
      logic [2:0]                 sendSts;
      logic                       irq;
   } cse_app_state_type;

   cse_app_state_type s_q, s_d;

   logic        regWr;
   logic [7:0]  regWrAddr;
   logic [31:0] regWrData;
   logic [3:0]  regWrStrb;
   logic [31:0] regRdData;

   ////////////////////////////////////////////////////////////////////////////
   // byte-lane merge for register writes
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : laneMerge

   // management address of header word n, word3 first; the words sit one word apart
   function automatic logic [11:0] hdrAddr(input logic [1:0] n);
      return `CSE_LMI_HDR3 + {8'h0, n, 2'h0};
   endfunction : hdrAddr

   ////////////////////////////////////////////////////////////////////////////
   // bus front end
   cse_axil_slave #(.ADDR_W(8)) u_cse_axil_slave (
      .mclk      (mclk),
      .reset     (reset),
      .awaddr    (awaddr),
      .awvalid   (awvalid),
      .awready   (awready),
      .wdata     (wdata),
      .wstrb     (wstrb),
      .wvalid    (wvalid),
      .wready    (wready),
      .bresp     (bresp),
      .bvalid    (bvalid),
      .bready    (bready),
      .araddr    (araddr),
      .arvalid   (arvalid),
      .arready   (arready),
      .rdata     (rdata),
      .rresp     (rresp),
      .rvalid    (rvalid),
      .rready    (rready),
      .regWr     (regWr),
      .regWrAddr (regWrAddr),
      .regWrData (regWrData),
      .regWrStrb (regWrStrb),
      .regRdData (regRdData)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   always_comb begin
      regRdData = 32'h0;
      if (araddr == `CSE_REG_CMD) begin
         regRdData = {23'h0, s_q.log, 5'h0, s_q.kind};
      end else if (araddr == `CSE_REG_STAT) begin
         regRdData = {28'h0, s_q.st != cse_pkg::APP_IDLE, s_q.stat};
      end else if (araddr == `CSE_REG_MASK) begin
         regRdData = {29'h0, s_q.mask};
      end else if (araddr == `CSE_REG_PEND) begin
         regRdData = {{(32-CNT_W){1'b0}}, s_q.count};
      end else if (araddr >= `CSE_REG_HDR0 && araddr <= `CSE_REG_HDR3) begin
         regRdData = s_q.hdr[araddr[3:2]]; // header words sit in address order
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: registers, outstanding count and the report sequence
   always_comb begin
      logic [`CSE_EV_W-1:0] ev;
      logic [`CSE_EV_W-1:0] clr;
      logic                 cmdWr;
      ev     = '0;
      clr    = '0;
      cmdWr  = 1'b0;
      s_d    = s_q;
      s_d.cplErr = 7'h0; // every report bit lives one cycle only
      // software writes
      if (regWr) begin
         if (regWrAddr == `CSE_REG_CMD) begin
            cmdWr = 1'b1;
         end else if (regWrAddr == `CSE_REG_STAT) begin
            clr = regWrData[`CSE_EV_W-1:0];
         end else if (regWrAddr == `CSE_REG_MASK) begin
            s_d.mask = 3'(laneMerge({29'h0, s_q.mask}, regWrData, regWrStrb));
         end else if (regWrAddr >= `CSE_REG_HDR0 && regWrAddr <= `CSE_REG_HDR3) begin
            s_d.hdr[regWrAddr[3:2]] = laneMerge(s_q.hdr[regWrAddr[3:2]], regWrData, regWrStrb);
         end
      end
      // outstanding completions; one with none awaited is unexpected
      if (cplRx && s_q.count == '0) begin
         s_d.ucPend = 1'b1;
         ev[`CSE_ST_UC] = 1'b1;
      end else begin
         s_d.count = s_q.count + CNT_W'(reqIssue) - CNT_W'(cplRx) - CNT_W'(reqRetire && s_q.count != '0);
      end
      // report sequence
      case (s_q.st)
         cse_pkg::APP_IDLE: begin
            if (cmdWr) begin
               s_d.kind = regWrData[2:0];
               s_d.log  = regWrData[`CSE_CMD_LOG];
               s_d.word = 2'h0;
               if (regWrData[2:0] > 3'(`CSE_ERR_NPUR)) begin
                  ev[`CSE_ST_REJECT] = 1'b1;
               end else if (regWrData[`CSE_CMD_LOG]) begin
                  s_d.st      = cse_pkg::APP_LOGW; // header goes out first
                  s_d.lmiWr   = 1'b1;
                  s_d.lmiAddr = hdrAddr(2'h0);
                  s_d.lmiDin  = s_q.hdr[3];
               end else if (regWrData[2:0] == 3'(`CSE_ERR_CA) || regWrData[2:0] == 3'(`CSE_ERR_NPUR)) begin
                  s_d.st      = cse_pkg::APP_CPLSEND;
                  s_d.sendReq = 1'b1;
                  s_d.sendSts = (regWrData[2:0] == 3'(`CSE_ERR_CA)) ? `CSE_CPL_STS_CA : `CSE_CPL_STS_UR;
               end else begin
                  s_d.st = cse_pkg::APP_REPORT;
               end
            end else if (s_q.ucPend) begin
               // hardware-found unexpected completion, reported unlogged
               s_d.ucPend = ev[`CSE_ST_UC]; // one arriving now stays queued
               s_d.kind   = 3'(`CSE_ERR_UC);
               s_d.log    = 1'b0;
               s_d.st     = cse_pkg::APP_REPORT;
            end
         end
         cse_pkg::APP_LOGW: begin
            // strobe held until acked, then next word
            if (side.lmiAck) begin
               s_d.word = s_q.word + 2'h1;
               if (s_q.word == 2'h3) begin
                  s_d.lmiWr = 1'b0;
                  if (s_q.kind == 3'(`CSE_ERR_CA) || s_q.kind == 3'(`CSE_ERR_NPUR)) begin
                     s_d.st      = cse_pkg::APP_CPLSEND;
                     s_d.sendReq = 1'b1;
                     s_d.sendSts = (s_q.kind == 3'(`CSE_ERR_CA)) ? `CSE_CPL_STS_CA : `CSE_CPL_STS_UR;
                  end else begin
                     s_d.st = cse_pkg::APP_REPORT;
                  end
               end else begin
                  s_d.lmiAddr = hdrAddr(s_q.word + 2'h1);
                  s_d.lmiDin  = s_q.hdr[2'h2 - s_q.word];
               end
            end
         end
         cse_pkg::APP_CPLSEND: begin
            // the error bit waits for the completion to leave
            if (cplSent) begin
               s_d.sendReq = 1'b0;
               s_d.st      = cse_pkg::APP_REPORT;
            end
         end
         cse_pkg::APP_REPORT: begin
            s_d.cplErr[s_q.kind] = 1'b1;
            s_d.cplErr[`CSE_ERR_LOG] = s_q.log && s_q.kind >= 3'(`CSE_ERR_CA);
            ev[`CSE_ST_DONE] = 1'b1;
            s_d.st = cse_pkg::APP_IDLE;
         end
         default: begin
            s_d.st = cse_pkg::APP_IDLE;
         end
      endcase
      // a new event beats a software clear in the same cycle
      s_d.stat = (s_q.stat & ~clr) | ev;
      s_d.irq  = |(s_d.stat & s_d.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state
   assign side.cplErr     = s_q.cplErr;
   assign side.cplPending = s_q.count != '0;
   assign side.lmiWr      = s_q.lmiWr;
   assign side.lmiAddr    = s_q.lmiAddr;
   assign side.lmiDin     = s_q.lmiDin;
   assign cplSendReq      = s_q.sendReq;
   assign cplSendSts      = s_q.sendSts;
   assign irq             = s_q.irq;

endmodule : cse_app_end

// ### rtl/cse_defs.svh
// constants of the completion error sideband: addresses, bit positions, register layout
`ifndef CSE_DEFS_SVH
`define CSE_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// error report bits on the sideband
`define CSE_ERR_TO_REC   0
`define CSE_ERR_TO_NOREC 1
`define CSE_ERR_CA       2
`define CSE_ERR_UC       3
`define CSE_ERR_PUR      4
`define CSE_ERR_NPUR     5
`define CSE_ERR_LOG      6
`define CSE_ERR_W        7

////////////////////////////////////////////////////////////////////////////////
// management addresses of the four header log words (word3 holds header 127..96)
`define CSE_LMI_HDR3     12'h81C
`define CSE_LMI_HDR2     12'h820
`define CSE_LMI_HDR1     12'h824
`define CSE_LMI_HDR0     12'h828
`define CSE_LMI_ADDR_W   12

////////////////////////////////////////////////////////////////////////////////
// device status bits kept by the core
`define CSE_DST_COR      0
`define CSE_DST_NONFATAL 1
`define CSE_DST_FATAL    2
`define CSE_DST_UR       3

////////////////////////////////////////////////////////////////////////////////
// application controller registers (byte offsets on the AXI4-Lite bus)
`define CSE_REG_CMD      8'h00
`define CSE_REG_STAT     8'h04
`define CSE_REG_MASK     8'h08
`define CSE_REG_PEND     8'h0C
`define CSE_REG_HDR0     8'h10
`define CSE_REG_HDR1     8'h14
`define CSE_REG_HDR2     8'h18
`define CSE_REG_HDR3     8'h1C
`define CSE_CMD_LOG      8
`define CSE_ST_DONE      0
`define CSE_ST_UC        1
`define CSE_ST_REJECT    2
`define CSE_ST_BUSY      3
`define CSE_EV_W         3
`define CSE_MASK_RESET   3'h0
`define CSE_CPL_STS_UR   3'h1
`define CSE_CPL_STS_CA   3'h4

`endif

// ### rtl/cse_pkg.sv
// types shared by both ends of the completion error sideband
package cse_pkg;

   // application controller sequence
   typedef enum logic [1:0] {
      APP_IDLE,
      APP_LOGW,
      APP_CPLSEND,
      APP_REPORT
   } cse_app_state_type;

   // error message kinds sent upstream by the core
   typedef enum logic [1:0] {
      MSG_NONE,
      MSG_COR,
      MSG_NONFATAL
   } cse_msg_type;

endpackage : cse_pkg

// ### rtl/cse_if.sv
// sideband between application logic and the transaction-layer core
`timescale 1ns/10ps
interface cse_if;
   logic [6:0]  cplErr;     // one-cycle error report pulses, bit 6 = log header
   logic        cplPending; // application waits for a completion
   logic        lmiWr;      // management write strobe, held until acked
   logic [11:0] lmiAddr;    // management address
   logic [31:0] lmiDin;     // management write data
   logic        lmiAck;     // one-cycle write acknowledge

   // the documented core
   modport core (input cplErr, input cplPending, input lmiWr, input lmiAddr, input lmiDin, output lmiAck);
   // the application layer above it
   modport app (output cplErr, output cplPending, output lmiWr, output lmiAddr, output lmiDin, input lmiAck);
endinterface : cse_if

// ### rtl/cse_core_end.sv
// core end: header log registers, configuration error status and error messages
`timescale 1ns/10ps
`include "cse_defs.svh"
module cse_core_end (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                reset,
   // sideband from the application
   cse_if.core                      side,
   // errors found by the transaction layer itself
   input  wire logic                tlUrDetect,
   input  wire logic                tlCorDetect,
   // status clear, write one per bit
   input  wire logic [3:0]          devStatusClr,
   // configuration status and messages
   output logic [3:0]               devStatus,
   output logic                     msgValid,
   output cse_pkg::cse_msg_type     msgKind,
   output logic                     hdrValid,
   output logic [127:0]             loggedHdr,
   output logic                     pendingOut
);

   ////////////////////////////////////////////////////////////////////////////
   // all state
   typedef struct packed {
      logic [3:0][31:0]     hdrLog;    // header log words, [3] = bits 127..96
      logic                 lmiAck;
      logic [3:0]           devStatus;
      logic                 msgValid;
      cse_pkg::cse_msg_type msgKind;
      logic                 hdrValid;
      logic [127:0]         loggedHdr;
      logic                 pending;
   } cse_core_state_type;

   cse_core_state_type s_q, s_d;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [6:0] e;
      logic       urHit;
      logic       nfHit;
      logic       corHit;
      e      = side.cplErr;
      // classify; several errors in one cycle are all recorded
      urHit  = e[`CSE_ERR_PUR] | e[`CSE_ERR_NPUR] | tlUrDetect;
      nfHit  = urHit | e[`CSE_ERR_TO_NOREC] | e[`CSE_ERR_CA] | e[`CSE_ERR_UC];
      corHit = e[`CSE_ERR_TO_REC] | tlCorDetect;
      s_d    = s_q;
      s_d.lmiAck   = 1'b0;
      s_d.msgValid = 1'b0;
      s_d.msgKind  = cse_pkg::MSG_NONE;
      s_d.hdrValid = 1'b0;
      s_d.pending  = side.cplPending;
      // one write per strobe; the ack cycle guards against a second write
      if (side.lmiWr && !s_q.lmiAck) begin
         s_d.lmiAck = 1'b1;
         if (side.lmiAddr == `CSE_LMI_HDR3) begin
            s_d.hdrLog[3] = side.lmiDin;
         end else if (side.lmiAddr == `CSE_LMI_HDR2) begin
            s_d.hdrLog[2] = side.lmiDin;
         end else if (side.lmiAddr == `CSE_LMI_HDR1) begin
            s_d.hdrLog[1] = side.lmiDin;
         end else if (side.lmiAddr == `CSE_LMI_HDR0) begin
            s_d.hdrLog[0] = side.lmiDin;
         end
      end
      // sticky status: a new error beats a clear in the same cycle
      s_d.devStatus = s_q.devStatus & ~devStatusClr;
      s_d.devStatus[`CSE_DST_UR]       = s_d.devStatus[`CSE_DST_UR] | urHit;
      s_d.devStatus[`CSE_DST_NONFATAL] = s_d.devStatus[`CSE_DST_NONFATAL] | nfHit;
      s_d.devStatus[`CSE_DST_COR]      = s_d.devStatus[`CSE_DST_COR] | corHit;
      // one message per cycle; the more severe kind wins
      if (nfHit) begin
         s_d.msgValid = 1'b1;
         s_d.msgKind  = cse_pkg::MSG_NONFATAL;
      end else if (corHit) begin
         s_d.msgValid = 1'b1;
         s_d.msgKind  = cse_pkg::MSG_COR;
      end
      // header capture only for the kinds that carry a logged header
      if (e[`CSE_ERR_LOG] && (|e[`CSE_ERR_NPUR:`CSE_ERR_CA])) begin
         s_d.hdrValid  = 1'b1;
         s_d.loggedHdr = s_q.hdrLog;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state
   assign side.lmiAck = s_q.lmiAck;
   assign devStatus   = s_q.devStatus;
   assign msgValid    = s_q.msgValid;
   assign msgKind     = s_q.msgKind;
   assign hdrValid    = s_q.hdrValid;
   assign loggedHdr   = s_q.loggedHdr;
   assign pendingOut  = s_q.pending;

endmodule : cse_core_end

// ### rtl/cse_axil_slave.sv
// AXI4-Lite slave front end: turns bus cycles into register strobes
`timescale 1ns/10ps
module cse_axil_slave #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // AXI4-Lite
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // register side
   output logic                   regWr,
   output logic [ADDR_W-1:0]      regWrAddr,
   output logic [31:0]            regWrData,
   output logic [3:0]             regWrStrb,
   input  wire logic [31:0]       regRdData
);

   ////////////////////////////////////////////////////////////////////////////
   // all state
   typedef struct packed {
      logic              awHave;
      logic              wHave;
      logic [ADDR_W-1:0] aw;
      logic [31:0]       wd;
      logic [3:0]        ws;
      logic              bvalid;
      logic              rvalid;
      logic [31:0]       rdata;
      logic              wr;
   } cse_axil_state_type;

   cse_axil_state_type s_q, s_d;

   ////////////////////////////////////////////////////////////////////////////
   // address and data may come in either order; the write fires once both are held
   always_comb begin
      s_d    = s_q;
      s_d.wr = 1'b0;
      if (awvalid && !s_q.awHave) begin
         s_d.awHave = 1'b1;
         s_d.aw     = awaddr;
      end
      if (wvalid && !s_q.wHave) begin
         s_d.wHave = 1'b1;
         s_d.wd    = wdata;
         s_d.ws    = wstrb;
      end
      if (s_q.awHave && s_q.wHave && !s_q.bvalid) begin
         s_d.wr     = 1'b1;
         s_d.bvalid = 1'b1;
      end
      // channels are reopened only when the response is taken
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
         s_d.awHave = 1'b0;
         s_d.wHave  = 1'b0;
      end
      // reads sample the register mux at the address handshake
      if (arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = regRdData;
      end else if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready   = !s_q.awHave;
   assign wready    = !s_q.wHave;
   assign bvalid    = s_q.bvalid;
   assign bresp     = 2'h0;
   assign arready   = !s_q.rvalid;
   assign rvalid    = s_q.rvalid;
   assign rdata     = s_q.rdata;
   assign rresp     = 2'h0;
   assign regWr     = s_q.wr;
   assign regWrAddr = s_q.aw;
   assign regWrData = s_q.wd;
   assign regWrStrb = s_q.ws;

endmodule : cse_axil_slave

// ### tb/cse_sideband_checker.sv
// assertions on the sideband between application and core
`timescale 1ns/10ps
module cse_sideband_checker (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [6:0]  cplErr,
   input wire logic [11:0] lmiAddr,
   input wire logic [31:0] lmiDin,
   input wire logic        lmiWr,
   input wire logic        lmiAck
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // error kinds are lone one-cycle pulses
   err_pulse_a: assert property (|cplErr[5:0] |=> !(|cplErr[5:0])) else $error("pulse too long");
   err_kind_a: assert property ($onehot0(cplErr[5:0])) else $error("two kinds");
   // header log bit only rides with a loggable error, never mid-write
   log_rides_a: assert property (cplErr[6] |-> |cplErr[5:2]) else $error("log alone");
   log_quiet_a: assert property (lmiWr |-> !cplErr[6]) else $error("log in write");
   // management writes hold, 820 follows 81C, none follows 828, and the first one gets a one-cycle ack
   hold_wr_a: assert property (lmiWr && !lmiAck |=> lmiWr && $stable(lmiAddr) && $stable(lmiDin))
      else $error("write dropped");
   word_order_a: assert property (lmiAck && lmiAddr == 12'h81C |=> lmiWr && lmiAddr == 12'h820)
      else $error("word order");
   last_word_a: assert property (lmiAck && lmiAddr == 12'h828 |=> !lmiWr) else $error("extra word");
   ack_due_a: assert property ($rose(lmiWr) |=> lmiAck ##1 !lmiAck) else $error("ack late");
endmodule : cse_sideband_checker

// ### tb/completion_error_sideband_tb.sv
// self-checking bench for both ends of the completion error sideband
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module completion_error_sideband_tb;
   // stimulus, all driven from the bench
   logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic tlUrDetect = 0, tlCorDetect = 0, reqIssue = 0, cplRx = 0, reqRetire = 0, cplSent = 0;
   logic [7:0]   awaddr = 0, araddr = 0;
   logic [31:0]  wdata = 0, rdata;
   logic [3:0]   wstrb = 4'hF, devStatusClr = 0, devStatus;
   logic         awready, wready, bvalid, arready, rvalid, msgValid, hdrValid, pendingOut, cplSendReq, irq;
   logic [1:0]   bresp, rresp;
   logic [2:0]   cplSendSts;
   logic [127:0] loggedHdr, hdr = 128'h0123456789ABCDEF_F0E1D2C3B4A59687;
   cse_pkg::cse_msg_type msgKind;
   int errors = 0, comparisons = 0;
   cse_if side ();
   cse_core_end u_cse_core_end (.*, .side(side.core));
   cse_app_end u_cse_app_end (.*, .side(side.app));
   cse_sideband_checker u_cse_sideband_checker (.mclk, .reset, .cplErr(side.cplErr), .lmiAddr(side.lmiAddr),
      .lmiDin(side.lmiDin), .lmiWr(side.lmiWr), .lmiAck(side.lmiAck));
   initial forever #12.5 mclk = ~mclk;
   // completion sender answers each request after one cycle
   always @(posedge mclk) cplSent <= cplSendReq && !cplSent;
   initial begin
      #200us errors++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do begin
         @(posedge mclk);
         if (awready) awvalid <= '0;
         if (wready) wvalid <= '0;
      end while (!bvalid);
      bready <= '0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk) {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(posedge mclk);
         if (arready) arvalid <= '0;
      end while (!rvalid);
      rready <= '0;
      `CHK("rdata", e, rdata)
   endtask : rd
   task conclude;
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      reset <= '0;
      rd(8'h0C, 32'h0);
      wr(8'h08, 32'h1);
      for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), hdr[32 * i +: 32]);
      wr(8'h00, 32'h104);
      @(posedge hdrValid) #1;
      `CHK("hdr", hdr, loggedHdr)
      `CHK("devst", 4'hA, devStatus)
      `CHK("msg", cse_pkg::MSG_NONFATAL, msgKind)
      `CHK("irq", 1'h1, irq)
      wr(8'h04, 32'h1);
      @(posedge mclk) #1 `CHK("irq", 1'h0, irq)
      // rejected non-posted requests go out as completion first, then the error bit
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk) devStatusClr <= 4'hF;
         @(posedge mclk) devStatusClr <= 4'h0;
         wr(8'h00, k ? 32'h2 : 32'h5);
         @(posedge cplSendReq) #1 `CHK("sts", k ? 3'h4 : 3'h1, cplSendSts)
         wait (side.cplErr[5] || side.cplErr[2]) #1;
         `CHK("err", k ? 7'h04 : 7'h20, side.cplErr)
         `CHK("cplreq", 1'h0, cplSendReq)
         @(posedge mclk) #1 `CHK("devst", k ? 4'h2 : 4'hA, devStatus)
      end
      // core's own errors land in the same cycle as a status clear, and win
      @(posedge mclk) {devStatusClr, tlUrDetect, tlCorDetect} <= {4'hF, 2'h3};
      @(posedge mclk) {devStatusClr, tlUrDetect, tlCorDetect} <= '0;
      @(posedge mclk) #1 `CHK("devst", 4'hB, devStatus)
      @(posedge mclk) reqIssue <= '1;
      @(posedge mclk) reqIssue <= '0;
      rd(8'h0C, 32'h1);
      `CHK("pend", 2'h3, {side.cplPending, pendingOut})
      // second completion matches nothing outstanding
      repeat (2) begin
         @(posedge mclk) cplRx <= '1;
         @(posedge mclk) cplRx <= '0;
      end
      #1 `CHK("pend", 2'h0, {side.cplPending, pendingOut})
      wait (side.cplErr[3]) #1 `CHK("err", 7'h08, side.cplErr)
      // a timed-out request leaves the count without a completion
      @(posedge mclk) reqIssue <= '1;
      @(posedge mclk) {reqIssue, reqRetire} <= 2'h1;
      @(posedge mclk) reqRetire <= '0;
      rd(8'h0C, 32'h0);
      rd(8'h04, 32'h3);
      // a recoverable timeout travels as a correctable message
      wr(8'h00, 32'h0);
      wait (side.cplErr[0]) #1 `CHK("err", 7'h01, side.cplErr)
      @(posedge mclk) #1 `CHK("msg", {1'b1, cse_pkg::MSG_COR}, {msgValid, msgKind})
      wr(8'h00, 32'h7);
      rd(8'h04, 32'h7);
      rd(8'h40, 32'h0);
      conclude();
   end
endmodule : completion_error_sideband_tb
